/* aacp_defines.vh */
// constants for the audio converter clock and power control block
`ifndef AACP_DEFINES_VH
`define AACP_DEFINES_VH
// control port register map
`define AACP_REG_POWER 8'h02
`define AACP_REG_ADC_CTL 8'h04
`define AACP_REG_RATIO 8'h05
`define AACP_REG_GAIN_B 8'h07
`define AACP_REG_GAIN_A 8'h08
`define AACP_REG_IN_SEL 8'h09
`define AACP_REG_STATUS 8'h0a
// reset values
`define AACP_RST_POWER 8'h01
`define AACP_RST_ADC_CTL 8'h00
`define AACP_RST_RATIO 8'h04
`define AACP_RST_GAIN 8'h00
`define AACP_RST_IN_SEL 8'h00
// field positions
`define AACP_PDN_BIT 0
`define AACP_FMT_BIT 0
`define AACP_FREEZE_BIT 1
`define AACP_HPF_EN_BIT 2
`define AACP_MASTER_BIT 3
`define AACP_FM_HI 7
`define AACP_FM_LO 6
`define AACP_BOOST_BIT 3
// speed modes
`define AACP_FM_SINGLE 2'h0
`define AACP_FM_DOUBLE 2'h1
`define AACP_FM_QUAD 2'h2
// ratio codes: 64x 96x 128x 192x 256x 384x 512x 768x 1024x
`define AACP_R64 4'h0
`define AACP_R96 4'h1
`define AACP_R128 4'h2
`define AACP_R256 4'h4
`define AACP_R512 4'h6
`define AACP_R1024 4'h8
// gain in half-decibel steps, +/-12 dB
`define AACP_GAIN_MAX 6'sh18
`define AACP_GAIN_MIN (-6'sh18)
// control port address, audio framing and startup
`define AACP_CHIP_ADDR 7'h4f
`define AACP_BITS_PER_FRAME 7'h40
`define AACP_HALF_FRAME 6'h20
`define AACP_SAMPLE_BITS 24
`define AACP_STARTUP_FRAMES 4'h4
`endif

/* aacp_top.v */
// audio converter clocking, power sequencing, offset filter and control port
`timescale 1ns/1ns
`include "aacp_defines.vh"

// How it works
// R1: host holds reset until supplies and clocks settle; reset restores every default.
// R2: after reset, power-down bit is set and the control port still answers.
// R3: host configures while powered down, then clears power-down to start up.
// R4: two-wire host waits 500 ns after reset release before its first start.
// R5: four-wire host waits 500 ns after reset release before chip select falls.
// R6: four-wire host keeps chip select high 1.0 us between transfers.
// R7: two-wire host leaves bus idle 4.7 us between stop and start.
// R8: single, double and quad speed modes chosen by the mode field.
// R9: master clock is integer multiple of frame clock; mode and ratio set relation.
// R10: ratio ranges checked per speed; 64x and 96x only as master.
// R11: as master, drive frame clock at sample rate, bit clock at 64x.
// R12: as slave, far end supplies frame clock derived from master clock.
// R13: as slave, bit clock is 48, 64 or 128x (single) or 48/64x.
// R14: offset estimate tracked per channel and subtracted while filter runs.
// R15: freeze holds offset estimates and keeps subtracting them.
// R16: one of six sources selected; pair four may add microphone boost.
// R17: per-channel gain in 0.5 dB steps, plus or minus 12 dB.
// R18: reset selects first line input and 0 dB gain.
// R19: output framing is 24-bit left-justified or two-channel inter-IC sound.
// R20: speed mode chooses ratio set; divider follows programmed ratio.
// R21: as master, frame clock changes on bit clock falling edges, 64 per frame.
module aacp_top #(
   parameter CLK_PER_MCLK = 2,
   parameter HPF_SHIFT = 10
) (
   input wire clk,
   input wire reset,
   input wire ctl_select_n,
   input wire control_bit_clock,
   input wire control_serial_in,
   output reg control_serial_out,
   output reg control_serial_out_oe,
   input wire frame_clock_in,
   input wire bit_clock_in,
   output reg frame_clock_out,
   output reg bit_clock_out,
   output reg audio_clk_oe,
   output reg serial_data_out,
   input wire sample_valid,
   input wire signed [23:0] sample_a,
   input wire signed [23:0] sample_b,
   output reg [2:0] input_select,
   output reg mic_boost,
   output reg signed [5:0] gain_stage_a,
   output reg signed [5:0] gain_stage_b,
   output reg analog_enable
);
   localparam ST_OFF = 3'h1;
   localparam ST_WAKE = 3'h2;
   localparam ST_RUN = 3'h4;
   localparam CP_ADDR = 3'h1;
   localparam CP_MAP = 3'h2;
   localparam CP_DATA = 3'h4;

   reg [7:0] power_q, adc_ctl_q, ratio_q, gain_b_q, gain_a_q, in_sel_q;
   reg [2:0] pstate_q;
   reg [3:0] wake_cnt_q;
   // control port
   reg cs_n_q, control_bit_clock_q;
   reg [2:0] cp_state_q;
   reg [2:0] cp_bit_q;
   reg [7:0] cp_sh_q, map_q, rd_sh_q;
   reg cp_read_q, cp_skip_q;
   // audio clocking
   reg [11:0] acc_q;
   reg bclk_q;
   reg [6:0] pos_q;
   reg fin_q, bin_q;
   reg [11:0] flen_q;
   reg [7:0] bits_q;
   reg clk_err_q;
   // offset filter and serializer
   reg signed [35:0] est_a_q, est_b_q;
   reg signed [23:0] hold_a_q, hold_b_q;
   reg [23:0] sh_q;

   wire [1:0] fm = adc_ctl_q[`AACP_FM_HI:`AACP_FM_LO];
   wire master = adc_ctl_q[`AACP_MASTER_BIT];
   wire fmt_i2s = adc_ctl_q[`AACP_FMT_BIT];
   wire [3:0] rcode = ratio_q[3:0];
   wire running = pstate_q[2];

   function [11:0] ratio_cycles;
      input [3:0] code;
      begin
         case (code)
            4'h0: ratio_cycles = 12'd64;
            4'h1: ratio_cycles = 12'd96;
            4'h2: ratio_cycles = 12'd128;
            4'h3: ratio_cycles = 12'd192;
            4'h4: ratio_cycles = 12'd256;
            4'h5: ratio_cycles = 12'd384;
            4'h6: ratio_cycles = 12'd512;
            4'h7: ratio_cycles = 12'd768;
            default: ratio_cycles = 12'd1024;
         endcase
      end
   endfunction

   // valid ratio set depends on speed mode; slow ratios need master
   reg ratio_ok;
   always @* begin
      case (fm) // see R8 see R10 see R20
         `AACP_FM_SINGLE: ratio_ok = rcode >= `AACP_R256 && rcode <= `AACP_R1024;
         `AACP_FM_DOUBLE: ratio_ok = rcode >= `AACP_R128 && rcode <= `AACP_R512;
         `AACP_FM_QUAD: ratio_ok = rcode <= `AACP_R256 && (master || rcode >= `AACP_R128);
         default: ratio_ok = 1'b0;
      endcase
   end

   // clk cycles per frame: ratio times clk-to-master-clock factor
   wire [11:0] frame_cyc = ratio_cycles(rcode) * CLK_PER_MCLK[11:0]; // see R9 see R20

   function [7:0] reg_read;
      input [7:0] a;
      begin
         case (a)
            `AACP_REG_POWER: reg_read = power_q;
            `AACP_REG_ADC_CTL: reg_read = adc_ctl_q;
            `AACP_REG_RATIO: reg_read = ratio_q;
            `AACP_REG_GAIN_B: reg_read = gain_b_q;
            `AACP_REG_GAIN_A: reg_read = gain_a_q;
            `AACP_REG_IN_SEL: reg_read = in_sel_q;
            `AACP_REG_STATUS: reg_read = {3'h0, clk_err_q, ~ratio_ok, pstate_q};
            default: reg_read = 8'h00;
         endcase
      end
   endfunction

   function [7:0] clamp_gain;
      input [7:0] v;
      begin
         if ($signed(v) > $signed({2'h0, `AACP_GAIN_MAX}))
            clamp_gain = {2'h0, `AACP_GAIN_MAX};
         else if ($signed(v) < $signed({2'h3, `AACP_GAIN_MIN}))
            clamp_gain = {2'h3, `AACP_GAIN_MIN};
         else
            clamp_gain = v;
      end
   endfunction

   // control port: four-wire, pins sampled on clk
   wire control_bit_clock_rise = control_bit_clock && !control_bit_clock_q;
   wire control_bit_clock_fall = !control_bit_clock && control_bit_clock_q;
   wire [7:0] cp_byte = {cp_sh_q[6:0], control_serial_in};
   wire wr_strobe = control_bit_clock_rise && !ctl_select_n && cp_bit_q == 3'h7 &&
                    cp_state_q == CP_DATA && !cp_read_q && !cp_skip_q;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         cs_n_q <= 1'b1;
         control_bit_clock_q <= 1'b0;
         cp_state_q <= CP_ADDR;
         cp_bit_q <= 3'h0;
         cp_sh_q <= 8'h00;
         map_q <= 8'h00;
         rd_sh_q <= 8'h00;
         cp_read_q <= 1'b0;
         cp_skip_q <= 1'b0;
         control_serial_out <= 1'b0;
         control_serial_out_oe <= 1'b0;
      end else begin
         cs_n_q <= ctl_select_n;
         control_bit_clock_q <= control_bit_clock;
         if (ctl_select_n) begin
            // a transfer ends with chip select; map is kept for the next read
            cp_state_q <= CP_ADDR;
            cp_bit_q <= 3'h0;
            cp_read_q <= 1'b0;
            cp_skip_q <= 1'b0;
            control_serial_out_oe <= 1'b0;
         end else begin
            if (control_bit_clock_rise) begin
               cp_sh_q <= cp_byte;
               cp_bit_q <= cp_bit_q + 3'h1;
               if (cp_bit_q == 3'h7) begin
                  case (cp_state_q)
                     CP_ADDR: begin
                        cp_skip_q <= cp_byte[7:1] != `AACP_CHIP_ADDR;
                        cp_read_q <= cp_byte[0];
                        cp_state_q <= cp_byte[0] ? CP_DATA : CP_MAP;
                        rd_sh_q <= reg_read(map_q);
                     end
                     CP_MAP: begin
                        if (!cp_skip_q)
                           map_q <= cp_byte;
                        cp_state_q <= CP_DATA;
                     end
                     CP_DATA: begin
                        if (!cp_skip_q)
                           map_q <= map_q + 8'h01;
                        rd_sh_q <= reg_read(map_q + 8'h01);
                     end
                     default: cp_state_q <= CP_ADDR;
                  endcase
               end
            end
            if (control_bit_clock_fall && cp_state_q == CP_DATA && cp_read_q && !cp_skip_q) begin
               control_serial_out <= rd_sh_q[3'h7 - cp_bit_q];
               control_serial_out_oe <= 1'b1;
            end
         end
      end
   end

   // register file; reset returns every setting to default
   always @(posedge clk or posedge reset) begin
      if (reset) begin // see R1
         power_q <= `AACP_RST_POWER; // see R2
         adc_ctl_q <= `AACP_RST_ADC_CTL;
         ratio_q <= `AACP_RST_RATIO;
         gain_b_q <= `AACP_RST_GAIN; // see R18
         gain_a_q <= `AACP_RST_GAIN;
         in_sel_q <= `AACP_RST_IN_SEL;
      end else if (wr_strobe) begin // see R3
         case (map_q)
            `AACP_REG_POWER: power_q <= cp_byte;
            `AACP_REG_ADC_CTL: adc_ctl_q <= cp_byte;
            `AACP_REG_RATIO: ratio_q <= cp_byte;
            `AACP_REG_GAIN_B: gain_b_q <= clamp_gain(cp_byte); // see R17
            `AACP_REG_GAIN_A: gain_a_q <= clamp_gain(cp_byte);
            // six sources, codes above five fall back to the first
            `AACP_REG_IN_SEL: in_sel_q <= (cp_byte[2:0] > 3'h5) ? // see R16
                                          {cp_byte[7:3], 3'h0} : cp_byte;
            default: ;
         endcase
      end
   end

   // frame events, common to master and slave timing
   wire bclk_toggle = acc_q + 12'd128 >= frame_cyc;
   wire m_fall = master && bclk_toggle && bclk_q;
   wire s_fall = !master && !bit_clock_in && bin_q;
   wire s_left = !master && (fmt_i2s ? (!frame_clock_in && fin_q) : (frame_clock_in && !fin_q));
   wire s_right = !master && (fmt_i2s ? (frame_clock_in && !fin_q) : (!frame_clock_in && fin_q));
   wire bit_fall = m_fall || s_fall;
   wire [6:0] pos_d = s_left ? 7'h00 : s_right ? {1'b0, `AACP_HALF_FRAME} :
                      (pos_q + 7'h01 == `AACP_BITS_PER_FRAME) ? 7'h00 : pos_q + 7'h01;
   wire [4:0] slot = pos_d[4:0];
   wire half_start = slot == 5'h00;
   wire data_on = fmt_i2s ? (slot >= 5'h01 && slot <= 5'h18) : (slot <= 5'h17); // see R19
   // in slave mode the frame is counted from the measured edges
   wire frame_go = running && ratio_ok && (master || !clk_err_q);

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         acc_q <= 12'h000;
         bclk_q <= 1'b0;
         pos_q <= 7'h3f;
         fin_q <= 1'b0;
         bin_q <= 1'b0;
         flen_q <= 12'h000;
         bits_q <= 8'h00;
         clk_err_q <= 1'b0;
         frame_clock_out <= 1'b0;
         bit_clock_out <= 1'b0;
         audio_clk_oe <= 1'b0;
         serial_data_out <= 1'b0;
         sh_q <= 24'h000000;
      end else begin
         fin_q <= frame_clock_in;
         bin_q <= bit_clock_in;
         audio_clk_oe <= master && frame_go; // see R11
         // bit clock from 128 half periods per frame
         if (!master || !frame_go) begin
            acc_q <= 12'h000;
            bclk_q <= 1'b0;
         end else if (bclk_toggle) begin // see R20
            acc_q <= acc_q + 12'd128 - frame_cyc;
            bclk_q <= !bclk_q;
         end else begin
            acc_q <= acc_q + 12'd128;
         end
         // follow the next bit clock value so frame edges land on its falling edge
         if (!master || !frame_go)
            bit_clock_out <= 1'b0;
         else if (bclk_toggle)
            bit_clock_out <= !bclk_q; // see R21
         else
            bit_clock_out <= bclk_q;
         // slave checks: frame length and bits per frame
         if (!master) begin
            flen_q <= s_left ? 12'h001 : flen_q + 12'h001;
            if (s_fall)
               bits_q <= bits_q + 8'h01;
            if (s_left) begin // see R12 see R13
               // a bit clock fall on the frame edge opens the new count
               bits_q <= s_fall ? 8'h01 : 8'h00;
               clk_err_q <= flen_q != frame_cyc ||
                            !(bits_q == 8'd48 || bits_q == 8'd64 ||
                              (bits_q == 8'd128 && fm == `AACP_FM_SINGLE));
            end
         end else begin
            clk_err_q <= 1'b0;
         end
         if (!frame_go) begin
            pos_q <= 7'h3f;
            serial_data_out <= 1'b0;
            frame_clock_out <= 1'b0;
         end else if (bit_fall) begin
            pos_q <= pos_d;
            // frame clock moves only with bit clock falling
            frame_clock_out <= fmt_i2s ? pos_d[5] : !pos_d[5]; // see R21 see R11
            if (half_start)
               sh_q <= pos_d[5] ? hold_b_q : hold_a_q;
            if (data_on) begin
               serial_data_out <= half_start ? (pos_d[5] ? hold_b_q[23] : hold_a_q[23])
                                             : sh_q[23];
               sh_q <= half_start ? {(pos_d[5] ? hold_b_q[22:0] : hold_a_q[22:0]), 1'b0}
                                  : {sh_q[22:0], 1'b0};
            end else begin
               serial_data_out <= 1'b0;
            end
         end
      end
   end

   // power sequencing; startup count advances once per clk cycle
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pstate_q <= ST_OFF;
         wake_cnt_q <= 4'h0;
         analog_enable <= 1'b0;
      end else begin
         case (pstate_q)
            ST_OFF: begin // see R2
               wake_cnt_q <= 4'h0;
               if (!power_q[`AACP_PDN_BIT] && ratio_ok)
                  pstate_q <= ST_WAKE; // see R3
            end
            ST_WAKE: begin
               if (power_q[`AACP_PDN_BIT])
                  pstate_q <= ST_OFF;
               else if (wake_cnt_q == `AACP_STARTUP_FRAMES)
                  pstate_q <= ST_RUN;
               else if (acc_q == 12'h000 || s_left || master)
                  wake_cnt_q <= wake_cnt_q + 4'h1;
            end
            ST_RUN: begin
               if (power_q[`AACP_PDN_BIT])
                  pstate_q <= ST_OFF;
            end
            default: pstate_q <= ST_OFF;
         endcase
         analog_enable <= !pstate_q[0];
      end
   end

   // offset removal; estimate is a slow running average
   wire hpf_on = adc_ctl_q[`AACP_HPF_EN_BIT];
   wire freeze = adc_ctl_q[`AACP_FREEZE_BIT];
   wire signed [35:0] xa = {sample_a, 12'h000};
   wire signed [35:0] xb = {sample_b, 12'h000};
   wire signed [35:0] ya = xa - est_a_q;
   wire signed [35:0] yb = xb - est_b_q;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         est_a_q <= 36'sh0;
         est_b_q <= 36'sh0;
         hold_a_q <= 24'sh0;
         hold_b_q <= 24'sh0;
      end else if (sample_valid && running) begin
         if (hpf_on && !freeze) begin // see R14
            est_a_q <= est_a_q + (ya >>> HPF_SHIFT);
            est_b_q <= est_b_q + (yb >>> HPF_SHIFT);
         end
         // frozen estimate is still subtracted
         hold_a_q <= (hpf_on || freeze) ? ya[35:12] : sample_a; // see R15
         hold_b_q <= (hpf_on || freeze) ? yb[35:12] : sample_b;
      end
   end

   // analog selection and gain controls
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         input_select <= 3'h0; // see R18
         mic_boost <= 1'b0;
         gain_stage_a <= 6'sh0;
         gain_stage_b <= 6'sh0;
      end else begin
         input_select <= in_sel_q[2:0]; // see R16
         mic_boost <= in_sel_q[`AACP_BOOST_BIT] && in_sel_q[2:0] == 3'h3;
         gain_stage_a <= gain_a_q[5:0]; // see R17
         gain_stage_b <= gain_b_q[5:0];
      end
   end
endmodule

/* aacp_chk.sv */
// assertion checker for the audio clock and power control block
`timescale 1ns/1ns
module aacp_chk (
   input wire clk,
   input wire reset,
   input wire ctl_select_n,
   input wire control_serial_out_oe,
   input wire frame_clock_out,
   input wire bit_clock_out,
   input wire audio_clk_oe,
   input wire [2:0] input_select,
   input wire mic_boost,
   input wire signed [5:0] gain_stage_a,
   input wire signed [5:0] gain_stage_b,
   input wire analog_enable
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // three samples, so registered outputs settle after the unsynchronised chip select rises
   sequence s_cs_idle;
      ctl_select_n [*3];
   endsequence
   sequence s_master_run;
      audio_clk_oe ##1 audio_clk_oe;
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0) reset |-> !analog_enable && !audio_clk_oe)
      else $error("outputs active during reset");
   a_wake_default: assert property ($fell(reset) |-> input_select == 3'h0 && gain_stage_a == 6'sh00 && gain_stage_b == 6'sh00 && !mic_boost)
      else $error("selection or gain not at default");
   a_stay_down: assert property ($fell(reset) |-> !analog_enable [*8])
      else $error("analog powered without request");
   a_out_release: assert property (s_cs_idle |-> !control_serial_out_oe)
      else $error("read data driven while deselected");
   a_gain_hold: assert property (s_cs_idle |-> $stable(gain_stage_a) && $stable(gain_stage_b) && $stable(input_select))
      else $error("setting changed without access");
   a_gain_range: assert property (gain_stage_a <= 6'sh18 && gain_stage_a >= -6'sh18 && gain_stage_b <= 6'sh18 && gain_stage_b >= -6'sh18)
      else $error("gain outside range");
   a_source_range: assert property (input_select <= 3'h5)
      else $error("source beyond six");
   a_boost_pair: assert property (mic_boost |-> input_select == 3'h3)
      else $error("boost on wrong source");
   a_frame_on_fall: assert property (s_master_run ##0 $changed(frame_clock_out) |-> $fell(bit_clock_out))
      else $error("frame edge off bit clock fall");
endmodule
bind aacp_top aacp_chk u_aacp_chk (.clk(clk), .reset(reset), .ctl_select_n(ctl_select_n),
   .control_serial_out_oe(control_serial_out_oe), .frame_clock_out(frame_clock_out),
   .bit_clock_out(bit_clock_out), .audio_clk_oe(audio_clk_oe), .input_select(input_select),
   .mic_boost(mic_boost), .gain_stage_a(gain_stage_a), .gain_stage_b(gain_stage_b),
   .analog_enable(analog_enable));

/* aacp_far_end.sv */
// far-end audio clock source for slave mode
`timescale 1ns/1ns
module aacp_far_end #(
   parameter HALF = 4
) (
   input wire clk,
   input wire reset,
   input wire enable,
   output reg frame_clock_in,
   output reg bit_clock_in
);
   reg [7:0] div_q;
   reg [5:0] pos_q;
   // both divide the one reference, so they cannot drift from it
   always @(posedge clk or posedge reset) begin
      if (reset || !enable) begin
         div_q <= 8'h00;
         pos_q <= 6'h00;
         bit_clock_in <= 1'b0;
         frame_clock_in <= 1'b0;
      end else if (div_q == HALF - 1) begin
         div_q <= 8'h00;
         bit_clock_in <= ~bit_clock_in;
         if (bit_clock_in) begin
            pos_q <= pos_q + 6'h01;
            frame_clock_in <= (pos_q + 6'h01) < 6'h20;
         end
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
endmodule

/* aacp_top_test.sv */
// self-checking bench for the audio clock and power control block
`timescale 1ns/1ns
`include "aacp_defines.vh"
module aacp_top_test;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg cs_n = 1'b1;
   reg cbc = 1'b0;
   reg csi = 1'b0;
   reg far_en = 1'b0;
   wire cso, cso_oe, fck_in, bck_in, fck, bck, aoe, sdo, boost, aen;
   wire [2:0] sel;
   wire signed [5:0] ga, gb;
   integer fail_count = 0;
   integer n_compared = 0;
   integer i, j;
   integer nb = 0;
   integer b0;
   reg [31:0] t0;
   reg [7:0] v;
   reg [24:0] rows [0:9];
   reg [15:0] rc [0:5];
   aacp_top u_aacp_top (.clk(clk), .reset(reset), .ctl_select_n(cs_n), .control_bit_clock(cbc),
      .control_serial_in(csi), .control_serial_out(cso), .control_serial_out_oe(cso_oe),
      .frame_clock_in(fck_in), .bit_clock_in(bck_in), .frame_clock_out(fck),
      .bit_clock_out(bck), .audio_clk_oe(aoe), .serial_data_out(sdo), .sample_valid(1'b0),
      .sample_a(24'h000000), .sample_b(24'h000000), .input_select(sel), .mic_boost(boost),
      .gain_stage_a(ga), .gain_stage_b(gb), .analog_enable(aen));
   aacp_far_end u_aacp_far_end (.clk(clk), .reset(reset), .enable(far_en),
      .frame_clock_in(fck_in), .bit_clock_in(bck_in));
   always #5 clk = ~clk;
   always @(posedge bck) nb = nb + 1;
   task check(input [31:0] seen, input [31:0] want);
      begin
         n_compared = n_compared + 1;
         if (seen !== want) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
         end
      end
   endtask
   task half;
      repeat (4) @(negedge clk);
   endtask
   task send(input [7:0] b);
      for (j = 7; j >= 0; j = j - 1) begin
         cbc = 1'b0;
         csi = b[j];
         half;
         cbc = 1'b1;
         half;
      end
   endtask
   task start;
      begin
         cs_n = 1'b0;
         half;
      end
   endtask
   task stop;
      begin
         cbc = 1'b0;
         half;
         cs_n = 1'b1;
         repeat (110) @(negedge clk);
      end
   endtask
   task wr(input [7:0] m, input [7:0] d);
      begin
         start;
         send({`AACP_CHIP_ADDR, 1'b0});
         send(m);
         send(d);
         stop;
      end
   endtask
   task rd(input [7:0] m);
      begin
         start;
         send({`AACP_CHIP_ADDR, 1'b0});
         send(m);
         stop;
         start;
         send({`AACP_CHIP_ADDR, 1'b1});
         for (j = 7; j >= 0; j = j - 1) begin
            cbc = 1'b0;
            half;
            v[j] = cso;
            cbc = 1'b1;
            half;
         end
         stop;
      end
   endtask
   task complete_run;
      begin
         if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      fail_count = fail_count + 1;
      complete_run;
   end
   initial begin
      // write flag, map, data, expected read back
      rows[0] = {1'b0, `AACP_REG_POWER, 8'h00, `AACP_RST_POWER};
      rows[1] = {1'b0, `AACP_REG_RATIO, 8'h00, `AACP_RST_RATIO};
      rows[2] = {1'b0, `AACP_REG_GAIN_B, 8'h00, `AACP_RST_GAIN};
      rows[3] = {1'b0, `AACP_REG_GAIN_A, 8'h00, `AACP_RST_GAIN};
      rows[4] = {1'b0, `AACP_REG_IN_SEL, 8'h00, `AACP_RST_IN_SEL};
      rows[5] = {1'b1, `AACP_REG_RATIO, 8'h06, 8'h06};
      rows[6] = {1'b1, `AACP_REG_GAIN_B, 8'h06, 8'h06};
      rows[7] = {1'b1, `AACP_REG_GAIN_A, 8'h18, 8'h18};
      rows[8] = {1'b1, `AACP_REG_IN_SEL, 8'h02, 8'h02};
      rows[9] = {1'b1, 8'h0f, 8'h55, 8'h00};
      // control value, ratio code, ratio refused
      rc[0] = {8'h00, `AACP_R256, 4'h0};
      rc[1] = {8'h00, `AACP_R128, 4'h1};
      rc[2] = {8'h40, `AACP_R128, 4'h0};
      rc[3] = {8'h40, `AACP_R1024, 4'h1};
      rc[4] = {8'h80, `AACP_R64, 4'h1};
      rc[5] = {8'h88, `AACP_R64, 4'h0};
      repeat (2) @(negedge clk);
      reset = 1'b0;
      repeat (60) @(negedge clk);
      for (i = 0; i < 10; i = i + 1) begin
         if (rows[i][24])
            wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         check(v, rows[i][7:0]);
      end
      check({26'h0, gb}, 32'h06);
      check(sel, 3'h2);
      check(aen, 1'b0);
      wr(`AACP_REG_GAIN_A, 8'h1c);
      check({26'h0, ga}, 32'h18);
      wr(`AACP_REG_GAIN_A, 8'he0);
      check({26'h0, ga}, 32'h28);
      wr(`AACP_REG_IN_SEL, 8'h0b);
      check({sel, boost}, 4'h7);
      wr(`AACP_REG_IN_SEL, 8'h0a);
      check({sel, boost}, 4'h4);
      for (i = 0; i < 6; i = i + 1) begin
         wr(`AACP_REG_ADC_CTL, rc[i][15:8]);
         wr(`AACP_REG_RATIO, {4'h0, rc[i][7:4]});
         rd(`AACP_REG_STATUS);
         check(v[3], rc[i][0]);
      end
      wr(`AACP_REG_ADC_CTL, 8'h08);
      wr(`AACP_REG_RATIO, {4'h0, `AACP_R256});
      wr(`AACP_REG_POWER, 8'h00);
      repeat (3000) @(negedge clk);
      rd(`AACP_REG_STATUS);
      check({aen, v[2:0]}, 4'hc);
      check(aoe, 1'b1);
      @(posedge fck);
      t0 = $time;
      b0 = nb;
      @(posedge fck);
      // 256 reference cycles of 2 clk each
      check($time - t0, 32'd5120);
      check(nb - b0, 32'd64);
      @(negedge clk);
      far_en = 1'b1;
      wr(`AACP_REG_ADC_CTL, 8'h00);
      repeat (3000) @(negedge clk);
      rd(`AACP_REG_STATUS);
      check(v, 8'h04);
      check(aoe, 1'b0);
      far_en = 1'b0;
      reset = 1'b1;
      repeat (2) @(negedge clk);
      check({aen, sel}, 4'h0);
      reset = 1'b0;
      repeat (60) @(negedge clk);
      rd(`AACP_REG_POWER);
      check(v, `AACP_RST_POWER);
      rd(`AACP_REG_GAIN_A);
      check(v, `AACP_RST_GAIN);
      complete_run;
   end
endmodule
